/* File: tcsync_pkg.sv */
// Package: register map, fields and reset values of the sync router
`default_nettype none
package tcsync_pkg;
  // Register indices; byte address is four times the index
  localparam logic [15:0] IDX_CTRL = 16'hfff0;
  localparam logic [15:0] IDX_CSR = 16'hfff1;
  localparam logic [15:0] IDX_CAP_RISE = 16'hfff2;
  localparam logic [15:0] IDX_CAP_FALL = 16'hfff3;
  localparam logic [15:0] IDX_COUNT = 16'hfff4;
  localparam logic [15:0] IDX_CMPB = 16'hfff5;
  localparam logic [15:0] IDX_IRQ_STAT = 16'hfff8;
  localparam logic [15:0] IDX_IRQ_MASK = 16'hfff9;
  localparam logic [15:0] IDX_IN_ROUTE = 16'hfffc;
  localparam logic [15:0] IDX_OUT_ROUTE = 16'hfffd;
  localparam logic [15:0] IDX_WIN_SEL = 16'hfffe;
  localparam logic [15:0] IDX_EDGE = 16'hffff;
  // Sync input mode codes
  typedef enum logic [1:0] {
    MODE_FLYBACK = 2'h0,
    MODE_SOG = 2'h1,
    MODE_SEPARATE = 2'h3,
    MODE_COMPOSITE = 2'h2
  } tcsync_mode_t;
  // Field positions
  localparam int OUT_HSYNC_BIT = 0;
  localparam int WIN_SEL_BIT = 0;
  localparam int CAP_SEL_BIT = 0;
  localparam int CTRL_RUN_BIT = 0;
  localparam int CTRL_CKS_LO = 1;
  localparam int CSR_CMFB = 7;
  localparam int CSR_OVF = 6;
  localparam int CSR_RISE = 5;
  localparam int CSR_FALL = 4;
  localparam int EDGE_FLAG_LO = 4;
  // Synchronised input lanes
  localparam int IN_HS = 0;
  localparam int IN_VS = 1;
  localparam int IN_CS = 2;
  localparam int IN_HFB = 3;
  localparam int IN_VFB = 4;
  localparam int IN_PDV = 5;
  localparam int IN_VT = 6;
  localparam int NUM_IN = 7;
  // Interrupt status bits
  localparam int IRQ_CMFB_X = 0;
  localparam int IRQ_CMFB_Y = 1;
  localparam int IRQ_CAPT = 2;
  localparam int IRQ_EDGE = 3;
  localparam int IRQ_W = 4;
  // Reset values and prescaler
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam logic [7:0] CMPB_RST = 8'hff;
  localparam logic [1:0] MODE_RST = 2'h0;
  localparam int PRE_W = 6;
endpackage : tcsync_pkg
`default_nettype wire

/* File: tcsync_router.sv */
// Timer connection: sync routing, two 8-bit timers, edge sense, APB regs
`default_nettype none
// Behaviour
// - Mode field routes flyback, sync-on-green, composite or separate inputs
// - Output select 1 drives horizontal sync on shared pin, else port
// - Window select steers timer range to first or second timer channel
// - Capture source select 1 picks pin, 0 internal vertical; resets 0
// - First channel status bits 7..4 clear on written 0 only
// - Second channel status bits 7..5 clear on written 0 only
// - Compare-match B flag sets when counter equals compare value B
// - Edge-sense flags clear only by writing 0; writing 1 does nothing
// - Edge-sense level bits show live pin states, no fixed value
module tcsync_router (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [17:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic horiz_sync_in,
  input wire logic vert_sync_in,
  input wire logic composite_sync_in,
  input wire logic horiz_flyback_in,
  input wire logic vert_flyback_in,
  input wire logic pseudo_derived_vertical,
  input wire logic vert_sync_or_timer_pin,
  input wire logic alt_pin_out,
  input wire logic alt_pin_oe,
  output logic shared_pin_out,
  output logic shared_pin_oe,
  output logic internal_horiz_signal,
  output logic internal_vert_signal,
  output logic irq
);
  logic [tcsync_pkg::NUM_IN-1:0] raw_in;
  logic [tcsync_pkg::NUM_IN-1:0] s1_q, s2_q, s3_q;
  logic [tcsync_pkg::NUM_IN-1:0] rise, fall;
  // APB slave state
  logic [31:0] prdata_q, prdata_d;
  logic pready_q, pready_d, pslverr_q, pslverr_d;
  // Routing registers
  logic [1:0] mode_q, mode_d;
  logic hs_out_sel_q, hs_out_sel_d, win_sel_q, win_sel_d;
  logic cap_sel_q, cap_sel_d;
  // Per-channel timer state, index 0 first channel, 1 second
  logic [7:0] ctrl_q [2], ctrl_d [2];
  logic [7:0] cnt_q [2], cnt_d [2];
  logic [7:0] cmpb_q [2], cmpb_d [2];
  logic [7:0] csr_q [2], csr_d [2];
  logic [7:0] cap_rise_q, cap_rise_d, cap_fall_q, cap_fall_d;
  logic [tcsync_pkg::PRE_W-1:0] pre_q, pre_d;
  logic [3:0] edge_q, edge_d;
  logic [tcsync_pkg::IRQ_W-1:0] ist_q, ist_d, imask_q, imask_d;
  // Registered pin and internal signal outputs
  logic pin_out_q, pin_out_d, pin_oe_q, pin_oe_d;
  logic ihs_q, ihs_d, ivs_q, ivs_d, irq_q, irq_d;
  logic ihs_c, ivs_c, cap_src, cap_src_prev, cap_rise_ev, cap_fall_ev;
  logic wr, setup;
  logic [15:0] idx;
  logic [7:0] wb;

  assign raw_in = {vert_sync_or_timer_pin, pseudo_derived_vertical,
                   vert_flyback_in, horiz_flyback_in, composite_sync_in,
                   vert_sync_in, horiz_sync_in};

  // Edges are taken from the second and third stages only
  assign rise = s2_q & ~s3_q;
  assign fall = ~s2_q & s3_q;
  assign idx = paddr[17:2];
  assign wb = pwdata[7:0];
  assign setup = psel & ~penable;
  assign wr = psel & penable & pready_q & pwrite;

  // Clock-select decode used for both channels
  function automatic logic tick(input logic [7:0] ctrl,
                                input logic [tcsync_pkg::PRE_W-1:0] pre);
    logic [1:0] cks;
    cks = ctrl[tcsync_pkg::CTRL_CKS_LO +: 2];
    tick = 1'b0;
    if (ctrl[tcsync_pkg::CTRL_RUN_BIT]) begin
      case (cks)
        2'h0: tick = 1'b1;
        2'h1: tick = pre[0];
        2'h2: tick = &pre[2:0];
        default: tick = &pre;
      endcase
    end
  endfunction : tick

  // Address decode shared by read and write paths
  function automatic logic mapped(input logic [15:0] a);
    mapped = (a >= tcsync_pkg::IDX_CTRL && a <= tcsync_pkg::IDX_CMPB) ||
             a == tcsync_pkg::IDX_IRQ_STAT || a == tcsync_pkg::IDX_IRQ_MASK ||
             a >= tcsync_pkg::IDX_IN_ROUTE;
  endfunction : mapped

  // Sync routing, mode decides the internal horizontal and vertical paths
  always_comb begin
    ihs_c = s2_q[tcsync_pkg::IN_HFB];
    ivs_c = s2_q[tcsync_pkg::IN_VFB];
    case (tcsync_pkg::tcsync_mode_t'(mode_q))
      tcsync_pkg::MODE_SOG: begin
        ihs_c = s2_q[tcsync_pkg::IN_CS];
        ivs_c = s2_q[tcsync_pkg::IN_PDV];
      end
      tcsync_pkg::MODE_COMPOSITE: begin
        ihs_c = s2_q[tcsync_pkg::IN_HS];
        ivs_c = s2_q[tcsync_pkg::IN_PDV];
      end
      tcsync_pkg::MODE_SEPARATE: begin
        ihs_c = s2_q[tcsync_pkg::IN_HS];
        ivs_c = s2_q[tcsync_pkg::IN_VS];
      end
      default: begin
        ihs_c = s2_q[tcsync_pkg::IN_HFB];
        ivs_c = s2_q[tcsync_pkg::IN_VFB];
      end
    endcase
  end

  // Capture trigger: pin or the routed vertical signal
  assign cap_src = cap_sel_q ? s2_q[tcsync_pkg::IN_VT] : ivs_c;
  assign cap_src_prev = cap_sel_q ? s3_q[tcsync_pkg::IN_VT] : ivs_q;
  assign cap_rise_ev = cap_src & ~cap_src_prev;
  assign cap_fall_ev = ~cap_src & cap_src_prev;

  // Next values for all state; hardware sets win over software clears
  always_comb begin
    logic [1:0] cmfb;
    logic [1:0] ovf;
    logic ch;
    mode_d = mode_q;
    hs_out_sel_d = hs_out_sel_q;
    win_sel_d = win_sel_q;
    cap_sel_d = cap_sel_q;
    ctrl_d = ctrl_q;
    cnt_d = cnt_q;
    cmpb_d = cmpb_q;
    csr_d = csr_q;
    cap_rise_d = cap_rise_q;
    cap_fall_d = cap_fall_q;
    edge_d = edge_q;
    ist_d = ist_q;
    imask_d = imask_q;
    pre_d = pre_q + 1'b1; // Free-running prescaler, wrap intended
    cmfb = 2'b00;
    ovf = 2'b00;
    ch = win_sel_q;
    // Software writes first so that events below override clears
    if (wr) begin
      if (idx == tcsync_pkg::IDX_IN_ROUTE) begin
        mode_d = wb[1:0];
      end else if (idx == tcsync_pkg::IDX_OUT_ROUTE) begin
        hs_out_sel_d = wb[tcsync_pkg::OUT_HSYNC_BIT];
      end else if (idx == tcsync_pkg::IDX_WIN_SEL) begin
        win_sel_d = wb[tcsync_pkg::WIN_SEL_BIT];
      end else if (idx == tcsync_pkg::IDX_EDGE) begin
        edge_d = edge_q & wb[7:tcsync_pkg::EDGE_FLAG_LO];
      end else if (idx == tcsync_pkg::IDX_IRQ_STAT) begin
        ist_d = ist_q & ~wb[tcsync_pkg::IRQ_W-1:0];
      end else if (idx == tcsync_pkg::IDX_IRQ_MASK) begin
        imask_d = wb[tcsync_pkg::IRQ_W-1:0];
      end else if (idx == tcsync_pkg::IDX_CTRL) begin
        ctrl_d[ch] = wb;
      end else if (idx == tcsync_pkg::IDX_CSR) begin
        // Flags only clear on a written zero, never set by a one
        if (ch) begin
          csr_d[1] = {csr_q[1][7:5] & wb[7:5], 5'h00};
        end else begin
          csr_d[0] = {csr_q[0][7:4] & wb[7:4], 4'h0};
        end
      end else if (idx == tcsync_pkg::IDX_CAP_RISE && ch) begin
        cap_sel_d = wb[tcsync_pkg::CAP_SEL_BIT];
      end else if (idx == tcsync_pkg::IDX_COUNT) begin
        cnt_d[ch] = wb;
      end else if (idx == tcsync_pkg::IDX_CMPB) begin
        cmpb_d[ch] = wb;
      end
    end
    // Counters and compare match B for both channels
    for (int i = 0; i < 2; i++) begin
      if (tick(ctrl_q[i], pre_q)) begin
        cnt_d[i] = cnt_q[i] + 8'h01;
        ovf[i] = &cnt_q[i];
      end
      cmfb[i] = (cnt_q[i] == cmpb_q[i]);
      if (cmfb[i]) begin
        csr_d[i][tcsync_pkg::CSR_CMFB] = 1'b1;
      end
      if (ovf[i]) begin
        csr_d[i][tcsync_pkg::CSR_OVF] = 1'b1;
      end
    end
    // Capture of the first counter on the selected trigger edges
    if (cap_rise_ev) begin
      cap_rise_d = cnt_q[0];
      csr_d[0][tcsync_pkg::CSR_RISE] = 1'b1;
    end
    if (cap_fall_ev) begin
      cap_fall_d = cnt_q[0];
      csr_d[0][tcsync_pkg::CSR_FALL] = 1'b1;
    end
    // Second channel notes rising edges of its timer input pin
    if (rise[tcsync_pkg::IN_VT]) begin
      csr_d[1][tcsync_pkg::CSR_RISE] = 1'b1;
    end
    // Edge-sense flags: vertical, horizontal, composite, flyback rise
    edge_d = edge_d | {rise[tcsync_pkg::IN_VS], rise[tcsync_pkg::IN_HS],
                       rise[tcsync_pkg::IN_CS], rise[tcsync_pkg::IN_HFB]};
    // Sticky interrupt sources
    ist_d[tcsync_pkg::IRQ_CMFB_X] = ist_d[tcsync_pkg::IRQ_CMFB_X] | cmfb[0];
    ist_d[tcsync_pkg::IRQ_CMFB_Y] = ist_d[tcsync_pkg::IRQ_CMFB_Y] | cmfb[1];
    ist_d[tcsync_pkg::IRQ_CAPT] = ist_d[tcsync_pkg::IRQ_CAPT] |
                                  cap_rise_ev | cap_fall_ev;
    ist_d[tcsync_pkg::IRQ_EDGE] = ist_d[tcsync_pkg::IRQ_EDGE] |
      rise[tcsync_pkg::IN_VS] | rise[tcsync_pkg::IN_HS] |
      rise[tcsync_pkg::IN_CS] | rise[tcsync_pkg::IN_HFB];
  end

  // Outputs: routed signals and the shared pin, all registered
  always_comb begin
    ihs_d = ihs_c;
    ivs_d = ivs_c;
    irq_d = |(ist_q & imask_q);
    if (hs_out_sel_q) begin
      pin_out_d = ihs_c;
      pin_oe_d = 1'b1;
    end else begin
      pin_out_d = alt_pin_out;
      pin_oe_d = alt_pin_oe;
    end
  end

  // APB answer: data fetched in setup, ready in the first access cycle
  always_comb begin
    logic ch;
    ch = win_sel_q;
    pready_d = setup;
    pslverr_d = setup & ~mapped(idx);
    prdata_d = prdata_q;
    if (setup) begin
      prdata_d = 32'h0000_0000;
      if (idx == tcsync_pkg::IDX_IN_ROUTE) begin
        prdata_d[1:0] = mode_q;
      end else if (idx == tcsync_pkg::IDX_OUT_ROUTE) begin
        prdata_d[tcsync_pkg::OUT_HSYNC_BIT] = hs_out_sel_q;
      end else if (idx == tcsync_pkg::IDX_WIN_SEL) begin
        prdata_d[tcsync_pkg::WIN_SEL_BIT] = win_sel_q;
      end else if (idx == tcsync_pkg::IDX_EDGE) begin
        prdata_d[7:0] = {edge_q, s2_q[tcsync_pkg::IN_VS],
                         s2_q[tcsync_pkg::IN_HS], s2_q[tcsync_pkg::IN_CS],
                         s2_q[tcsync_pkg::IN_HFB]};
      end else if (idx == tcsync_pkg::IDX_IRQ_STAT) begin
        prdata_d[tcsync_pkg::IRQ_W-1:0] = ist_q;
      end else if (idx == tcsync_pkg::IDX_IRQ_MASK) begin
        prdata_d[tcsync_pkg::IRQ_W-1:0] = imask_q;
      end else if (idx == tcsync_pkg::IDX_CTRL) begin
        prdata_d[7:0] = ctrl_q[ch];
      end else if (idx == tcsync_pkg::IDX_CSR) begin
        prdata_d[7:0] = csr_q[ch];
      end else if (idx == tcsync_pkg::IDX_CAP_RISE) begin
        prdata_d[7:0] = ch ? {7'h00, cap_sel_q} : cap_rise_q;
      end else if (idx == tcsync_pkg::IDX_CAP_FALL) begin
        prdata_d[7:0] = ch ? tcsync_pkg::BYTE_RST : cap_fall_q;
      end else if (idx == tcsync_pkg::IDX_COUNT) begin
        prdata_d[7:0] = cnt_q[ch];
      end else if (idx == tcsync_pkg::IDX_CMPB) begin
        prdata_d[7:0] = cmpb_q[ch];
      end
    end
  end

  // Input synchronisers; pins are asynchronous to pclk
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else begin
      s1_q <= raw_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // State registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_q <= tcsync_pkg::MODE_RST;
      hs_out_sel_q <= 1'b0;
      win_sel_q <= 1'b0;
      cap_sel_q <= 1'b0;
      for (int i = 0; i < 2; i++) begin
        ctrl_q[i] <= tcsync_pkg::BYTE_RST;
        cnt_q[i] <= tcsync_pkg::BYTE_RST;
        cmpb_q[i] <= tcsync_pkg::CMPB_RST;
        csr_q[i] <= tcsync_pkg::BYTE_RST;
      end
      cap_rise_q <= tcsync_pkg::BYTE_RST;
      cap_fall_q <= tcsync_pkg::BYTE_RST;
      pre_q <= '0;
      edge_q <= '0;
      ist_q <= '0;
      imask_q <= '0;
    end else begin
      mode_q <= mode_d;
      hs_out_sel_q <= hs_out_sel_d;
      win_sel_q <= win_sel_d;
      cap_sel_q <= cap_sel_d;
      ctrl_q <= ctrl_d;
      cnt_q <= cnt_d;
      cmpb_q <= cmpb_d;
      csr_q <= csr_d;
      cap_rise_q <= cap_rise_d;
      cap_fall_q <= cap_fall_d;
      pre_q <= pre_d;
      edge_q <= edge_d;
      ist_q <= ist_d;
      imask_q <= imask_d;
    end
  end

  // Output and bus answer registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_out_q <= 1'b0;
      pin_oe_q <= 1'b0;
      ihs_q <= 1'b0;
      ivs_q <= 1'b0;
      irq_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      pin_out_q <= pin_out_d;
      pin_oe_q <= pin_oe_d;
      ihs_q <= ihs_d;
      ivs_q <= ivs_d;
      irq_q <= irq_d;
      prdata_q <= prdata_d;
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign shared_pin_out = pin_out_q;
  assign shared_pin_oe = pin_oe_q;
  assign internal_horiz_signal = ihs_q;
  assign internal_vert_signal = ivs_q;
  assign irq = irq_q;
endmodule : tcsync_router
`default_nettype wire

/* File: tcsync_sync_src.sv */
// Model of the external video sync sources that feed the router pins
`default_nettype none
module tcsync_sync_src (
  input wire logic pclk,
  input wire logic [6:0] lvl,
  output logic hs,
  output logic vs,
  output logic cs,
  output logic hfb,
  output logic vfb,
  output logic pdv,
  output logic vt
);
  timeunit 1ns;
  timeprecision 1ps;
  // Pins sit low from time zero, so reset never sees a floating source
  initial {vt, pdv, vfb, hfb, cs, vs, hs} = 7'h00;
  // Levels move just after an edge, like a source locked to the bus clock
  always @(posedge pclk) begin
    {vt, pdv, vfb, hfb, cs, vs, hs} <= lvl;
  end
endmodule : tcsync_sync_src
`default_nettype wire

/* File: tcsync_checker.sv */
// Port-level assertions for the sync router, bound to its top module
`default_nettype none
module tcsync_checker (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [17:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic horiz_sync_in,
  input wire logic vert_sync_in,
  input wire logic composite_sync_in,
  input wire logic horiz_flyback_in,
  input wire logic vert_flyback_in,
  input wire logic pseudo_derived_vertical,
  input wire logic vert_sync_or_timer_pin,
  input wire logic alt_pin_out,
  input wire logic alt_pin_oe,
  input wire logic shared_pin_out,
  input wire logic shared_pin_oe,
  input wire logic internal_horiz_signal,
  input wire logic internal_vert_signal,
  input wire logic irq
);
  logic [1:0] mode_q, mode_d;
  logic osel_q, osel_d;
  logic [2:0] age_q, age_d;
  logic [15:0] idx;
  logic [6:0] pins;
  logic unmapped;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Shadow routing fields from completed writes; age hides reset history
  always_comb begin
    idx = paddr[17:2];
    pins = {vert_sync_or_timer_pin, pseudo_derived_vertical, vert_flyback_in,
      horiz_flyback_in, composite_sync_in, vert_sync_in, horiz_sync_in};
    unmapped = idx < tcsync_pkg::IDX_CTRL ||
      idx inside {16'hfff6, 16'hfff7, 16'hfffa, 16'hfffb};
    mode_d = mode_q;
    osel_d = osel_q;
    age_d = (age_q == 3'h7) ? age_q : age_q + 3'h1;
    if (psel && penable && pready && pwrite) begin
      if (idx == tcsync_pkg::IDX_IN_ROUTE) mode_d = pwdata[1:0];
      if (idx == tcsync_pkg::IDX_OUT_ROUTE) osel_d = pwdata[0];
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_q <= 2'h0;
      osel_q <= 1'b0;
      age_q <= 3'h0;
    end else begin
      mode_q <= mode_d;
      osel_q <= osel_d;
      age_q <= age_d;
    end
  end
  // Source picked by mode code, vertical when v is set
  function automatic logic pick(input logic [1:0] m, input logic [6:0] p,
      input logic v);
    case (m)
      2'h0: pick = v ? p[4] : p[3];
      2'h1: pick = v ? p[5] : p[2];
      2'h2: pick = v ? p[5] : p[0];
      default: pick = v ? p[1] : p[0];
    endcase
  endfunction : pick
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_access;
    psel && penable && pready;
  endsequence
  AST_READY_NEXT: assert property (s_setup |=> s_access)
    else $error("pready missing after setup");
  AST_READY_ONE: assert property (pready |=> !pready)
    else $error("pready held past one cycle");
  AST_ERR_SET: assert property (s_access ##0 unmapped |-> pslverr)
    else $error("unmapped access without pslverr");
  AST_ERR_ONLY: assert property (pslverr |-> pready && unmapped)
    else $error("pslverr without unmapped access");
  AST_RD_ZERO: assert property (s_access ##0 !pwrite |->
    prdata[31:8] == 24'h0 && (!unmapped || prdata == 32'h0))
    else $error("read data bits not zero");
  AST_ROUTE_H: assert property (age_q > 3'h3 |->
    internal_horiz_signal == pick($past(mode_q), $past(pins, 3), 1'b0))
    else $error("horizontal routing wrong");
  AST_ROUTE_V: assert property (age_q > 3'h3 |->
    internal_vert_signal == pick($past(mode_q), $past(pins, 3), 1'b1))
    else $error("vertical routing wrong");
  AST_PIN_OUT: assert property (age_q > 3'h1 |-> shared_pin_out ==
    ($past(osel_q) ? internal_horiz_signal : $past(alt_pin_out)))
    else $error("shared pin level wrong");
  AST_PIN_OE: assert property (age_q > 3'h1 |->
    shared_pin_oe == ($past(osel_q) || $past(alt_pin_oe)))
    else $error("shared pin enable wrong");
endmodule : tcsync_checker
bind tcsync_router tcsync_checker chk (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .horiz_sync_in(horiz_sync_in), .vert_sync_in(vert_sync_in),
  .composite_sync_in(composite_sync_in), .horiz_flyback_in(horiz_flyback_in),
  .vert_flyback_in(vert_flyback_in),
  .vert_sync_or_timer_pin(vert_sync_or_timer_pin),
  .pseudo_derived_vertical(pseudo_derived_vertical), .irq(irq),
  .alt_pin_out(alt_pin_out), .alt_pin_oe(alt_pin_oe),
  .shared_pin_out(shared_pin_out), .shared_pin_oe(shared_pin_oe),
  .internal_horiz_signal(internal_horiz_signal),
  .internal_vert_signal(internal_vert_signal));
`default_nettype wire

/* File: testbench.sv */
// Self-checking bench: APB register tests and sync routing of the router
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [17:0] paddr = 18'h0;
  logic [31:0] pwdata = 32'h0;
  logic alt_pin_out = 1'b0;
  logic alt_pin_oe = 1'b0;
  logic [6:0] lvl = 7'h00;
  logic [6:0] pat [3] = '{7'h15, 7'h2a, 7'h4c};
  logic [31:0] prdata, rd;
  logic pready, pslverr, err, hs, vs, cs, hfb, vfb, pdv, vt;
  logic shared_pin_out, shared_pin_oe, ih, iv, irq;
  int n_errors = 0;
  int cmp_count = 0;
  // 100 MHz bus clock
  always #5 pclk = ~pclk;
  tcsync_sync_src src (.pclk(pclk), .lvl(lvl), .hs(hs), .vs(vs), .cs(cs),
    .hfb(hfb), .vfb(vfb), .pdv(pdv), .vt(vt));
  tcsync_router dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .horiz_sync_in(hs), .vert_sync_in(vs), .composite_sync_in(cs),
    .horiz_flyback_in(hfb), .vert_flyback_in(vfb),
    .pseudo_derived_vertical(pdv), .vert_sync_or_timer_pin(vt),
    .alt_pin_out(alt_pin_out), .alt_pin_oe(alt_pin_oe),
    .shared_pin_out(shared_pin_out), .shared_pin_oe(shared_pin_oe),
    .internal_horiz_signal(ih), .internal_vert_signal(iv), .irq(irq));
  task automatic chk(input string what, input logic [31:0] e,
      input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", what, e, g);
    end
  endtask : chk
  // Answer taken at the rising edge where pready is high, pre-edge values
  task automatic apb(input logic w, input logic [15:0] idx,
      input logic [7:0] wd);
    int n;
    logic rdy;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h0, wd};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      rdy = pready;
      rd = prdata;
      err = pslverr;
      n++;
    end while (rdy !== 1'b1 && n < 20);
    chk("pready", 32'h1, {31'h0, rdy});
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rdc(input string what, input logic [15:0] idx,
      input logic [7:0] e);
    apb(1'b0, idx, 8'h00);
    chk(what, {24'h0, e}, rd);
  endtask : rdc
  // Let pin levels pass the synchronisers; the bus must sit idle meanwhile
  task automatic settle();
    repeat (6) @(posedge pclk);
    @(negedge pclk);
    chk("pready_idle", 32'h0, {31'h0, pready});
  endtask : settle
  // Routed pair {vertical, horizontal} for a mode code and pin pattern
  function automatic logic [1:0] route(input logic [1:0] m,
      input logic [6:0] p);
    case (m)
      2'h0: route = {p[4], p[3]};
      2'h1: route = {p[5], p[2]};
      2'h2: route = {p[5], p[0]};
      default: route = {p[1], p[0]};
    endcase
  endfunction : route
  task automatic give_verdict();
    $display("TB: %0d compares, %0d mismatches", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : give_verdict
  // Watchdog: the tests need a few hundred cycles
  initial begin
    #200us;
    n_errors++;
    give_verdict();
  end
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    rdc("cap_rise", tcsync_pkg::IDX_CAP_RISE, 8'h00);
    rdc("cap_fall", tcsync_pkg::IDX_CAP_FALL, 8'h00);
    rdc("edge", tcsync_pkg::IDX_EDGE, 8'h00);
    $display("TB: reset test done");
    for (int m = 0; m < 4; m++) begin
      apb(1'b1, tcsync_pkg::IDX_IN_ROUTE, m[7:0]);
      foreach (pat[i]) begin
        lvl <= pat[i];
        settle();
        chk("route", {30'h0, route(m[1:0], pat[i])}, {30'h0, iv, ih});
        @(posedge pclk);
      end
    end
    $display("TB: routing test done");
    // Shared pin: select on with hsync low/high, then port function
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, tcsync_pkg::IDX_OUT_ROUTE, {7'h0, i < 2});
      lvl <= {6'h0, i[0]};
      alt_pin_out <= i[0] ^ ~i[1];
      alt_pin_oe <= ~i[0];
      repeat (6) @(posedge pclk);
      @(negedge pclk);
      chk("pin", {30'h0, i != 3, i[0]},
        {30'h0, shared_pin_oe, shared_pin_out});
    end
    $display("TB: shared pin test done");
    lvl <= 7'h00;
    apb(1'b1, tcsync_pkg::IDX_EDGE, 8'h00);
    apb(1'b1, tcsync_pkg::IDX_COUNT, 8'h3c);
    apb(1'b1, tcsync_pkg::IDX_CSR, 8'h00);
    rdc("edge_clr", tcsync_pkg::IDX_EDGE, 8'h00);
    lvl <= 7'h02;
    repeat (6) @(posedge pclk);
    rdc("edge_rise", tcsync_pkg::IDX_EDGE, 8'h88);
    apb(1'b1, tcsync_pkg::IDX_EDGE, 8'hff);
    rdc("edge_w1", tcsync_pkg::IDX_EDGE, 8'h88);
    apb(1'b1, tcsync_pkg::IDX_EDGE, 8'h00);
    rdc("edge_w0", tcsync_pkg::IDX_EDGE, 8'h08);
    apb(1'b1, tcsync_pkg::IDX_COUNT, 8'h5a);
    lvl <= 7'h00;
    repeat (6) @(posedge pclk);
    rdc("cap_rise", tcsync_pkg::IDX_CAP_RISE, 8'h3c);
    rdc("cap_fall", tcsync_pkg::IDX_CAP_FALL, 8'h5a);
    rdc("csr_caps", tcsync_pkg::IDX_CSR, 8'h30);
    apb(1'b1, tcsync_pkg::IDX_CSR, 8'hef);
    rdc("csr_w0", tcsync_pkg::IDX_CSR, 8'h20);
    $display("TB: capture and edge test done");
    apb(1'b1, tcsync_pkg::IDX_CMPB, 8'h5a);
    rdc("csr_match", tcsync_pkg::IDX_CSR, 8'ha0);
    chk("irq_masked", 32'h0, {31'h0, irq});
    apb(1'b1, tcsync_pkg::IDX_IRQ_MASK, 8'h01);
    settle();
    chk("irq_on", 32'h1, {31'h0, irq});
    apb(1'b1, tcsync_pkg::IDX_CSR, 8'hff);
    rdc("csr_w1", tcsync_pkg::IDX_CSR, 8'ha0);
    apb(1'b1, tcsync_pkg::IDX_WIN_SEL, 8'h01);
    // Timer pin rose during the routing test, so its flag is still set
    rdc("csr_y", tcsync_pkg::IDX_CSR, 8'h20);
    rdc("cap_sel", tcsync_pkg::IDX_CAP_RISE, 8'h00);
    apb(1'b1, tcsync_pkg::IDX_CAP_RISE, 8'h01);
    rdc("cap_sel", tcsync_pkg::IDX_CAP_RISE, 8'h01);
    apb(1'b1, tcsync_pkg::IDX_CMPB, 8'h00);
    apb(1'b1, tcsync_pkg::IDX_CSR, 8'hff);
    rdc("csr_y_w1", tcsync_pkg::IDX_CSR, 8'ha0);
    apb(1'b1, tcsync_pkg::IDX_CMPB, 8'h01);
    apb(1'b1, tcsync_pkg::IDX_CSR, 8'h7f);
    rdc("csr_y_w0", tcsync_pkg::IDX_CSR, 8'h20);
    apb(1'b1, tcsync_pkg::IDX_WIN_SEL, 8'h00);
    apb(1'b1, tcsync_pkg::IDX_CMPB, 8'h11);
    apb(1'b1, tcsync_pkg::IDX_CSR, 8'h7f);
    rdc("csr_x_w0", tcsync_pkg::IDX_CSR, 8'h20);
    apb(1'b1, tcsync_pkg::IDX_IRQ_STAT, 8'h0f);
    rdc("irq_stat", tcsync_pkg::IDX_IRQ_STAT, 8'h00);
    chk("irq_off", 32'h0, {31'h0, irq});
    $display("TB: compare and interrupt test done");
    apb(1'b0, 16'hfffa, 8'h00);
    chk("unmapped_err", 32'h1, {31'h0, err});
    chk("unmapped_data", 32'h0, rd);
    apb(1'b1, tcsync_pkg::IDX_CAP_RISE, 8'hff);
    chk("ro_err", 32'h0, {31'h0, err});
    rdc("cap_ro", tcsync_pkg::IDX_CAP_RISE, 8'h3c);
    $display("TB: refusal test done");
    // Run at full rate: one count per clock from the edge after enabling
    apb(1'b1, tcsync_pkg::IDX_COUNT, 8'h00);
    apb(1'b1, tcsync_pkg::IDX_CTRL, 8'h01);
    rdc("cnt_run", tcsync_pkg::IDX_COUNT, 8'h01);
    apb(1'b1, tcsync_pkg::IDX_CTRL, 8'h00);
    rdc("cnt_stop", tcsync_pkg::IDX_COUNT, 8'h06);
    $display("TB: counter test done");
    give_verdict();
  end
endmodule : testbench
`default_nettype wire
